/* File: scm_pkg.sv */
// Package: register map, field positions, reset values and etu timing
package scm_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [31:0] SERIAL_MODE_CFG_IDX = 32'hffff_fe80;
    localparam logic [31:0] BIT_RATE_DIVISOR_IDX = 32'hffff_fe82;
    localparam logic [31:0] SERIAL_CONTROL_IDX = 32'hffff_fe84;
    localparam logic [31:0] TRANSMIT_BUFFER_IDX = 32'hffff_fe86;
    localparam logic [31:0] SERIAL_FLAGS_IDX = 32'hffff_fe88;
    localparam logic [31:0] RECEIVE_BUFFER_IDX = 32'hffff_fe8a;
    localparam logic [31:0] CARD_MODE_CFG_IDX = 32'hffff_fe8c;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] SERIAL_MODE_CFG_RST = 8'h00;
    localparam logic [7:0] BIT_RATE_DIVISOR_RST = 8'hff;
    localparam logic [7:0] SERIAL_CONTROL_RST = 8'h00;
    localparam logic [7:0] TRANSMIT_BUFFER_RST = 8'hff;
    localparam logic [7:0] SERIAL_FLAGS_RST = 8'h84;
    localparam logic [7:0] RECEIVE_BUFFER_RST = 8'h00;
    localparam logic [2:0] CARD_MODE_CFG_RST = 3'h0;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int MODE_GUARD_SEL = 7;
    localparam int MODE_PARITY_EN = 5;
    localparam int MODE_ODD = 4;
    localparam int MODE_CKS_LSB = 0;
    localparam int CTRL_TIE = 7;
    localparam int CTRL_RIE = 6;
    localparam int CTRL_TE = 5;
    localparam int CTRL_RE = 4;
    localparam int FLG_TX_BUFFER_EMPTY_FLAG = 7;
    localparam int FLG_RX_FULL_FLAG = 6;
    localparam int FLG_OVERRUN_FLAG = 5;
    localparam int FLG_ERS = 4;
    localparam int FLG_PER = 3;
    localparam int FLG_TX_DONE_FLAG = 2;
    localparam int CMR_BIT_ORDER = 3;
    localparam int CMR_DATA_INV = 2;
    localparam int CMR_CARD_MODE = 0;

    // ****************************************************************
    // Frame timing, counted in half-etu ticks from the start edge
    // ****************************************************************
    localparam logic [4:0] HE_START_CHK = 5'd1;
    localparam logic [4:0] HE_RX_D0 = 5'd3;
    localparam logic [4:0] HE_RX_D7 = 5'd17;
    localparam logic [4:0] HE_RX_PAR = 5'd19;
    localparam logic [4:0] HE_RX_STOP_P = 5'd21;
    localparam logic [4:0] HE_ERRSIG_ON = 5'd21;
    localparam logic [4:0] HE_ERRSIG_OFF = 5'd23;
    localparam logic [4:0] HE_ERR_SMP = 5'd22;
    localparam logic [4:0] HE_TX_DONE_FLAG_GSM0 = 5'd25;
    localparam logic [4:0] HE_TX_DONE_FLAG_GSM1 = 5'd22;
    localparam logic [4:0] HE_GUARD_GSM0 = 5'd25;
    localparam logic [4:0] HE_GUARD_GSM1 = 5'd24;
    localparam logic [4:0] HE_RETX = 5'd26;
    localparam logic [4:0] HE_END_P = 5'd22;
    localparam logic [4:0] HE_END_NP = 5'd20;
    localparam int unsigned HALF_ETU_BASE_DEF = 372;

    typedef enum {TX_IDLE, TX_BUSY} scm_tx_e;
    typedef enum {RX_IDLE, RX_BUSY} scm_rx_e;

endpackage : scm_pkg

/* File: scm_baud_if.sv */
// Interface: bit rate settings and half-etu tick between core and generator
`timescale 1ns/1ps
`default_nettype none
interface scm_baud_if;
    logic [1:0] cks;
    logic [7:0] divisor;
    logic restart;
    logic half_tick;
    modport core (output cks, output divisor, output restart,
        input half_tick);
    modport gen (input cks, input divisor, input restart,
        output half_tick);
endinterface : scm_baud_if
`default_nettype wire

/* File: scm_baud.sv */
// Baud rate generator producing one pulse per half etu
`timescale 1ns/1ps
`default_nettype none
module scm_baud #(
    parameter int unsigned HALF_BASE = scm_pkg::HALF_ETU_BASE_DEF
) (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, high
    scm_baud_if.gen bif // Settings in, tick out
);
    logic [15:0] pre_r;
    logic [7:0] div_r;
    logic tick_r;
    logic [15:0] pre_lim;

    // Shifted base must still fit the 16-bit prescaler
    if (HALF_BASE < 1 || HALF_BASE > 1023) begin : g_bad_base
        $error("HALF_BASE out of range");
    end

    // Prescale of base times 4^n, then divisor plus one
    assign pre_lim = 16'((32'(HALF_BASE) << {bif.cks, 1'b0}) - 32'd1);
    assign bif.half_tick = tick_r;

    always_ff @(posedge clk) begin
        if (rst || bif.restart) begin
            pre_r <= '0;
            div_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (pre_r == pre_lim) begin
                pre_r <= '0;
                if (div_r == bif.divisor) begin
                    div_r <= '0;
                    tick_r <= 1'b1;
                end else begin
                    div_r <= div_r + 8'h01;
                end
            end else begin
                pre_r <= pre_r + 16'h0001;
            end
        end
    end
endmodule : scm_baud
`default_nettype wire

/* File: scm_top.sv */
// Serial unit with smart card mode: APB registers, transmitter, receiver
// Operation
// - Ordinary or card mode chosen by registers
// - Card mode select bit enables card function
// - Card mode generates and checks parity
// - Bit order bit selects LSB or MSB first
// - Invert bit inverts data on send, store
// - Inversion never alters the parity bit
// - Card config bits cleared by reset, standby
// - Unused card config bits unwritable, read as zero
// - Low error sample while sending sets flag
// - Error flag cleared by reset, standby, write
// - Clearing transmit enable keeps error flag
// - Status bit 4 is error flag in card mode, framing error in ordinary mode
// - Returned error signal causes automatic resend
// - Receive parity error drives error signal back
// - Done flag clears on empty-clear or buffer write
// - Done flag set at reset, or idle
// - Guard select 0: done after 2.5 etu
// - Guard select 1: done after 1.0 etu
// - Three separate independent interrupt requests
// - Bit rate from on-chip rate generator
// - Reset returns all registers to initial values
// - Frame: start, eight data, parity, release
// - At least 2 etu guard before next frame
// - Parity error: low 1 etu at 10.5 etu
// - Resend at least 2 etu after error sample
`timescale 1ns/1ps
`default_nettype none
module scm_top #(
    parameter int unsigned HALF_ETU_BASE = scm_pkg::HALF_ETU_BASE_DEF
) (
    input wire logic MCLK, // Clock, 40 MHz
    input wire logic SRST, // Synchronous reset, high
    input wire logic STANDBY, // Standby entry, clears state
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB enable
    input wire logic PWRITE, // APB direction
    input wire logic [11:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error, unmapped address
    input wire logic DATA_I, // Data line level
    output logic DATA_O, // Data line drive value
    output logic DATA_OE_N, // Data line enable, low drives
    output logic TXI_REQ, // Transmit-data-empty request
    output logic RXI_REQ, // Receive-data-full request
    output logic ERI_REQ // Communication-error request
);
    // ****************************************************************
    // Registers and bus decode
    // ****************************************************************
    logic rst;
    logic [7:0] mode_r, brr_r, ctrl_r, tdr_r, rdr_r;
    logic [2:0] cmr_r;
    logic tx_buffer_empty_flag_r, rx_full_flag_r, overrun_flag_r, fe_r, per_r, tx_done_flag_r;
    logic [7:0] flags, seen_r, rdata;
    logic access, wr_en, rd_en, hit;
    logic sel_mode, sel_brr, sel_ctrl, sel_tdr, sel_flg, sel_rdr, sel_cmr;
    logic card, inv, msb, odd, gsm, te, re, pe_on;
    logic wflag;

    assign rst = SRST || STANDBY;
    assign access = PSEL && PENABLE && PREADY;
    assign wr_en = access && PWRITE;
    assign rd_en = access && !PWRITE;
    assign sel_mode = PADDR[11:2] == scm_pkg::SERIAL_MODE_CFG_IDX[9:0];
    assign sel_brr = PADDR[11:2] == scm_pkg::BIT_RATE_DIVISOR_IDX[9:0];
    assign sel_ctrl = PADDR[11:2] == scm_pkg::SERIAL_CONTROL_IDX[9:0];
    assign sel_tdr = PADDR[11:2] == scm_pkg::TRANSMIT_BUFFER_IDX[9:0];
    assign sel_flg = PADDR[11:2] == scm_pkg::SERIAL_FLAGS_IDX[9:0];
    assign sel_rdr = PADDR[11:2] == scm_pkg::RECEIVE_BUFFER_IDX[9:0];
    assign sel_cmr = PADDR[11:2] == scm_pkg::CARD_MODE_CFG_IDX[9:0];
    assign hit = sel_mode || sel_brr || sel_ctrl || sel_tdr || sel_flg ||
        sel_rdr || sel_cmr;
    assign wflag = wr_en && sel_flg;

    assign card = cmr_r[scm_pkg::CMR_CARD_MODE];
    // Packed as {order, invert, mode}
    assign inv = cmr_r[1];
    assign msb = cmr_r[2];
    assign odd = mode_r[scm_pkg::MODE_ODD];
    assign gsm = mode_r[scm_pkg::MODE_GUARD_SEL];
    assign te = ctrl_r[scm_pkg::CTRL_TE];
    assign re = ctrl_r[scm_pkg::CTRL_RE];
    assign pe_on = card || mode_r[scm_pkg::MODE_PARITY_EN];
    assign flags = {tx_buffer_empty_flag_r, rx_full_flag_r, overrun_flag_r, fe_r, per_r, tx_done_flag_r, 2'b00};

    always_comb begin
        rdata = 8'h00;
        if (sel_mode) rdata = mode_r;
        if (sel_brr) rdata = brr_r;
        if (sel_ctrl) rdata = ctrl_r;
        if (sel_tdr) rdata = tdr_r;
        if (sel_flg) rdata = flags;
        if (sel_rdr) rdata = rdr_r;
        if (sel_cmr) rdata = {4'h0, cmr_r[2:1], 1'b0, cmr_r[0]};
    end

    // Zero wait states: answer flops load during the setup cycle
    always_ff @(posedge MCLK) begin
        if (rst) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= '0;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !hit;
            PRDATA <= {24'h00_0000, rdata};
        end
    end

    always_ff @(posedge MCLK) begin
        if (rst) begin
            mode_r <= scm_pkg::SERIAL_MODE_CFG_RST;
            brr_r <= scm_pkg::BIT_RATE_DIVISOR_RST;
            ctrl_r <= scm_pkg::SERIAL_CONTROL_RST;
            tdr_r <= scm_pkg::TRANSMIT_BUFFER_RST;
            cmr_r <= scm_pkg::CARD_MODE_CFG_RST;
        end else if (wr_en) begin
            if (sel_mode) mode_r <= PWDATA[7:0];
            if (sel_brr) brr_r <= PWDATA[7:0];
            if (sel_ctrl) ctrl_r <= PWDATA[7:0];
            if (sel_tdr) tdr_r <= PWDATA[7:0];
            if (sel_cmr) begin
                cmr_r <= {PWDATA[3], PWDATA[2], PWDATA[0]};
            end
        end
    end

    // Clear by zero only for bits seen as one by an earlier read
    always_ff @(posedge MCLK) begin
        if (rst) begin
            seen_r <= '0;
        end else if (rd_en && sel_flg) begin
            // What software saw, not a flag that rose since setup
            seen_r <= PRDATA[7:0];
        end else if (wflag) begin
            seen_r <= '0;
        end
    end

    // ****************************************************************
    // Rate generator
    // ****************************************************************
    scm_baud_if bif ();
    logic tx_go, rx_go, retx;

    assign bif.cks = mode_r[scm_pkg::MODE_CKS_LSB +: 2];
    assign bif.divisor = brr_r;
    assign bif.restart = tx_go || rx_go || retx;

    scm_baud #(.HALF_BASE(HALF_ETU_BASE)) u_baud (
        .clk(MCLK),
        .rst(rst),
        .bif(bif)
    );

    function automatic logic [7:0] reorder(input logic [7:0] d,
        input logic rev);
        logic [7:0] r;
        r = d;
        if (rev) begin
            for (int i = 0; i < 8; i++) r[i] = d[7 - i];
        end
        return r;
    endfunction : reorder

    // ****************************************************************
    // Transmitter
    // ****************************************************************
    scm_pkg::scm_tx_e tx_st_r;
    scm_pkg::scm_rx_e rx_st_r;
    logic [4:0] txh_r, tx_nxt, tx_end;
    logic [8:0] frm_r;
    logic [3:0] idx;
    logic tx_err_r, tx_lvl, err_smp, tx_done_flag_evt, tx_tick;

    assign tx_go = tx_st_r == scm_pkg::TX_IDLE && te && !tx_buffer_empty_flag_r &&
        rx_st_r == scm_pkg::RX_IDLE;
    assign tx_tick = tx_st_r == scm_pkg::TX_BUSY && bif.half_tick;
    assign tx_nxt = txh_r + 5'd1;
    assign err_smp = tx_tick && card && tx_nxt == scm_pkg::HE_ERR_SMP &&
        !DATA_I;
    always_comb begin
        tx_end = pe_on ? scm_pkg::HE_END_P : scm_pkg::HE_END_NP;
        if (card) begin
            if (tx_err_r) tx_end = scm_pkg::HE_RETX;
            else if (gsm) tx_end = scm_pkg::HE_GUARD_GSM1;
            else tx_end = scm_pkg::HE_GUARD_GSM0;
        end
    end
    assign retx = tx_tick && card && tx_err_r && tx_nxt == tx_end;
    always_comb begin
        tx_done_flag_evt = 1'b0;
        if (tx_tick && tx_buffer_empty_flag_r && !fe_r && !tx_err_r && !err_smp) begin
            if (!card) tx_done_flag_evt = tx_nxt == tx_end;
            else if (gsm) tx_done_flag_evt = tx_nxt == scm_pkg::HE_TX_DONE_FLAG_GSM1;
            else tx_done_flag_evt = tx_nxt == scm_pkg::HE_TX_DONE_FLAG_GSM0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (rst || !te) begin
            tx_st_r <= scm_pkg::TX_IDLE;
            txh_r <= '0;
            tx_err_r <= 1'b0;
            frm_r <= '1;
        end else if (tx_go) begin
            tx_st_r <= scm_pkg::TX_BUSY;
            txh_r <= '0;
            tx_err_r <= 1'b0;
            // Parity over buffer data, so inversion leaves it alone
            frm_r <= {^tdr_r ^ odd,
                reorder(tdr_r, msb) ^ {8{inv}}};
        end else if (tx_tick) begin
            txh_r <= tx_nxt;
            if (err_smp) tx_err_r <= 1'b1;
            if (retx) begin
                txh_r <= '0;
                tx_err_r <= 1'b0;
            end else if (tx_nxt == tx_end) begin
                tx_st_r <= scm_pkg::TX_IDLE;
            end
        end
    end

    // Line level from half-etu position
    assign idx = txh_r[4:1];
    always_comb begin
        tx_lvl = 1'b1;
        if (tx_st_r == scm_pkg::TX_BUSY) begin
            if (idx == 4'd0) tx_lvl = 1'b0;
            else if (idx <= 4'd8) tx_lvl = frm_r[3'(idx - 4'd1)];
            else if (idx == 4'd9 && pe_on) tx_lvl = frm_r[8];
        end
    end

    // ****************************************************************
    // Receiver
    // ****************************************************************
    logic [4:0] rxh_r, rx_nxt, rx_stop;
    logic [8:0] raw_r;
    logic [7:0] rx_data;
    logic line_prev_r, err_drv_r, rx_tick, par_bad, rx_done, rx_perr;

    assign rx_go = rx_st_r == scm_pkg::RX_IDLE && re && !tx_go &&
        tx_st_r == scm_pkg::TX_IDLE && line_prev_r && !DATA_I;
    assign rx_tick = rx_st_r == scm_pkg::RX_BUSY && bif.half_tick;
    assign rx_nxt = rxh_r + 5'd1;
    assign rx_stop = pe_on ? scm_pkg::HE_RX_STOP_P : scm_pkg::HE_RX_PAR;
    assign rx_data = reorder(raw_r[7:0] ^ {8{inv}}, msb);
    assign par_bad = pe_on && (^rx_data ^ raw_r[8] ^ odd);
    assign rx_done = rx_tick && rx_nxt == rx_stop;
    assign rx_perr = rx_done && par_bad;

    always_ff @(posedge MCLK) begin
        if (rst) begin
            line_prev_r <= 1'b1;
        end else begin
            line_prev_r <= DATA_I;
        end
    end

    always_ff @(posedge MCLK) begin
        if (rst || !re) begin
            rx_st_r <= scm_pkg::RX_IDLE;
            rxh_r <= '0;
            raw_r <= '0;
            err_drv_r <= 1'b0;
        end else if (rx_go) begin
            rx_st_r <= scm_pkg::RX_BUSY;
            rxh_r <= '0;
        end else if (rx_tick) begin
            rxh_r <= rx_nxt;
            if (rx_nxt == scm_pkg::HE_START_CHK && DATA_I) begin
                rx_st_r <= scm_pkg::RX_IDLE; // Glitch, not a start bit
            end
            if (rx_nxt >= scm_pkg::HE_RX_D0 && rx_nxt <= scm_pkg::HE_RX_D7 &&
                rx_nxt[0]) begin
                raw_r[3'((rx_nxt - scm_pkg::HE_RX_D0) >> 1)] <= DATA_I;
            end
            if (rx_nxt == scm_pkg::HE_RX_PAR && pe_on) raw_r[8] <= DATA_I;
            if (rx_perr && card) begin
                err_drv_r <= 1'b1;
            end else if (rx_done) begin
                rx_st_r <= scm_pkg::RX_IDLE;
            end
            if (rx_nxt == scm_pkg::HE_ERRSIG_OFF) begin
                err_drv_r <= 1'b0;
                rx_st_r <= scm_pkg::RX_IDLE;
            end
        end
    end

    // Card mode drops a faulty character, the sender repeats it
    always_ff @(posedge MCLK) begin
        if (rst) begin
            rdr_r <= scm_pkg::RECEIVE_BUFFER_RST;
        end else if (rx_done && !rx_full_flag_r && !(card && par_bad)) begin
            rdr_r <= rx_data;
        end
    end

    // ****************************************************************
    // Status flags: a hardware set wins over a software clear
    // ****************************************************************
    logic tx_buffer_empty_flag_clr;
    assign tx_buffer_empty_flag_clr = wflag && !PWDATA[scm_pkg::FLG_TX_BUFFER_EMPTY_FLAG] &&
        seen_r[scm_pkg::FLG_TX_BUFFER_EMPTY_FLAG];

    always_ff @(posedge MCLK) begin
        if (rst) begin
            tx_buffer_empty_flag_r <= scm_pkg::SERIAL_FLAGS_RST[scm_pkg::FLG_TX_BUFFER_EMPTY_FLAG];
            rx_full_flag_r <= scm_pkg::SERIAL_FLAGS_RST[scm_pkg::FLG_RX_FULL_FLAG];
            overrun_flag_r <= scm_pkg::SERIAL_FLAGS_RST[scm_pkg::FLG_OVERRUN_FLAG];
            fe_r <= scm_pkg::SERIAL_FLAGS_RST[scm_pkg::FLG_ERS];
            per_r <= scm_pkg::SERIAL_FLAGS_RST[scm_pkg::FLG_PER];
            tx_done_flag_r <= scm_pkg::SERIAL_FLAGS_RST[scm_pkg::FLG_TX_DONE_FLAG];
        end else begin
            if (tx_go) tx_buffer_empty_flag_r <= 1'b1;
            else if (tx_buffer_empty_flag_clr || (wr_en && sel_tdr)) tx_buffer_empty_flag_r <= 1'b0;
            if (rx_done && !rx_full_flag_r && !(card && par_bad)) rx_full_flag_r <= 1'b1;
            else if (wflag && !PWDATA[scm_pkg::FLG_RX_FULL_FLAG] &&
                seen_r[scm_pkg::FLG_RX_FULL_FLAG]) rx_full_flag_r <= 1'b0;
            if (rx_done && rx_full_flag_r) overrun_flag_r <= 1'b1;
            else if (wflag && !PWDATA[scm_pkg::FLG_OVERRUN_FLAG] &&
                seen_r[scm_pkg::FLG_OVERRUN_FLAG]) overrun_flag_r <= 1'b0;
            // Card: error signal seen; ordinary: bad stop bit; not TE
            if (err_smp || (!card && rx_done && !DATA_I)) begin
                fe_r <= 1'b1;
            end else if (wflag && !PWDATA[scm_pkg::FLG_ERS] &&
                seen_r[scm_pkg::FLG_ERS]) begin
                fe_r <= 1'b0;
            end
            if (rx_perr) per_r <= 1'b1;
            else if (wflag && !PWDATA[scm_pkg::FLG_PER] &&
                seen_r[scm_pkg::FLG_PER]) per_r <= 1'b0;
            if (tx_done_flag_evt || (!te && !fe_r)) begin
                tx_done_flag_r <= 1'b1;
            end else if (tx_buffer_empty_flag_clr || (wr_en && sel_tdr)) begin
                tx_done_flag_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Pins and requests
    // ****************************************************************
    always_ff @(posedge MCLK) begin
        if (rst) begin
            DATA_O <= 1'b1;
            DATA_OE_N <= 1'b1;
            TXI_REQ <= 1'b0;
            RXI_REQ <= 1'b0;
            ERI_REQ <= 1'b0;
        end else begin
            // Card line is open drain: only lows are driven
            if (card) begin
                DATA_O <= 1'b0;
                DATA_OE_N <= tx_lvl && !err_drv_r;
            end else begin
                DATA_O <= tx_lvl;
                DATA_OE_N <= !te;
            end
            TXI_REQ <= ctrl_r[scm_pkg::CTRL_TIE] && tx_buffer_empty_flag_r;
            RXI_REQ <= ctrl_r[scm_pkg::CTRL_RIE] && rx_full_flag_r;
            ERI_REQ <= ctrl_r[scm_pkg::CTRL_RIE] &&
                (overrun_flag_r || fe_r || per_r);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_err_seen;
        err_smp ##1 tx_st_r == scm_pkg::TX_BUSY;
    endsequence
    sequence s_tdr_write;
        wr_en && sel_tdr && !tx_done_flag_evt && te;
    endsequence

    a_cmr_reserved: assert property (@(posedge MCLK) disable iff (rst)
        PSEL && !PENABLE && !PWRITE && sel_cmr |=> PRDATA[7:4] == 4'h0 &&
        PRDATA[1] == 1'b0) else $error("card cfg reserved bits not zero");
    a_cmr_cleared: assert property (@(posedge MCLK)
        SRST || STANDBY |=> cmr_r == 3'h0) else $error("card cfg not cleared");
    a_ers_set: assert property (@(posedge MCLK) disable iff (rst)
        s_err_seen |-> fe_r) else $error("error flag not set on low sample");
    a_ers_te_keep: assert property (@(posedge MCLK) disable iff (rst)
        fe_r && !wflag |=> fe_r) else $error("error flag lost");
    a_tx_done_flag_idle: assert property (@(posedge MCLK) disable iff (rst)
        !te && !fe_r |=> tx_done_flag_r) else $error("done flag not set when idle");
    a_tx_done_flag_clear: assert property (@(posedge MCLK) disable iff (rst)
        s_tdr_write |=> !tx_done_flag_r) else $error("done flag not cleared");
    a_retx_restart: assert property (@(posedge MCLK) disable iff (rst)
        retx |=> txh_r == 5'd0 && tx_st_r == scm_pkg::TX_BUSY && !tx_err_r)
        else $error("resend did not restart frame");
    a_errsig_start: assert property (@(posedge MCLK) disable iff (rst)
        $rose(err_drv_r) |-> rxh_r == scm_pkg::HE_ERRSIG_ON && card)
        else $error("error signal started at wrong time");
    a_start_low: assert property (@(posedge MCLK) disable iff (rst)
        tx_go ##1 card |=> !DATA_OE_N) else $error("start bit not driven");
    a_pready_next: assert property (@(posedge MCLK) disable iff (rst)
        PSEL && !PENABLE |=> PREADY ##1 !PREADY)
        else $error("bus answer not one cycle");
endmodule : scm_top
`default_nettype wire

/* File: scm_card_model.sv */
// Card model: samples each frame on the shared line, answers error signals
`timescale 1ns/1ps
`default_nettype none
module scm_card_model #(
    parameter int ETU = 8
) (
    input wire logic clk, // Clock
    input wire logic line, // Resolved data line
    input wire logic nak, // Answer the next frame with an error signal
    output logic drv_n, // Low pulls the line down
    output var logic [8:0] got // Last frame, first bit in bit 8
);
    initial begin
        drv_n = 1'b1;
        got = 9'h000;
        forever begin
            @(negedge line);
            // Mid-bit sampling keeps clear of the bit edges
            repeat (ETU / 2) @(posedge clk);
            for (int i = 0; i < 9; i++) begin
                repeat (ETU) @(posedge clk);
                got = {got[7:0], line};
            end
            repeat (ETU) @(posedge clk);
            drv_n <= !nak;
            repeat (ETU) @(posedge clk);
            drv_n <= 1'b1;
        end
    end
endmodule : scm_card_model
`default_nettype wire

/* File: smart_card_serial_mode_test.sv */
// Testbench: registers and card-mode transmit against a card model
`timescale 1ns/1ps
`default_nettype none
module smart_card_serial_mode_test;
    logic MCLK = 1'b0;
    logic SRST = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, DATA_O, DATA_OE_N, DRV_N;
    logic TXI_REQ, RXI_REQ, ERI_REQ;
    logic NAK = 1'b0;
    logic STANDBY = 1'b0;
    // Card-to-device frames from the bench, low pulls the line
    logic SND_N = 1'b1;
    logic [8:0] got, q;
    int bad_count = 0;
    int checks = 0;
    // Pull-up: a released line reads high
    wire logic LINE = (DATA_OE_N | DATA_O) & DRV_N & SND_N;
    scm_top #(.HALF_ETU_BASE(4)) dut_u (.MCLK(MCLK), .SRST(SRST),
        .STANDBY(STANDBY), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .DATA_I(LINE), .DATA_O(DATA_O),
        .DATA_OE_N(DATA_OE_N), .TXI_REQ(TXI_REQ), .RXI_REQ(RXI_REQ),
        .ERI_REQ(ERI_REQ));
    scm_card_model #(.ETU(8)) card_u (.clk(MCLK), .line(LINE), .nak(NAK),
        .drv_n(DRV_N), .got(got));
    initial forever #12.5 MCLK = ~MCLK;
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [7:0] d);
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= {24'h00_0000, d};
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do @(posedge MCLK); while (PREADY !== 1'b1);
        q = {PSLVERR, PRDATA[7:0]};
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic rd(input logic [11:0] a, input logic [8:0] e);
        apb(1'b0, a, 8'h00);
        chk(q, e);
    endtask : rd
    // Start bit, then f[8] down to f[0], one etu of 8 cycles each
    task automatic send(input logic [8:0] f);
        SND_N <= 1'b0;
        repeat (8) @(posedge MCLK);
        for (int i = 8; i >= 0; i--) begin
            SND_N <= f[i];
            repeat (8) @(posedge MCLK);
        end
        SND_N <= 1'b1;
    endtask : send
    task automatic print_verdict;
        if (bad_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (5000) @(posedge MCLK);
        bad_count++;
        print_verdict();
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (10) @(posedge MCLK);
        SRST <= 1'b0;
        rd(12'ha20, 9'h084);
        rd(12'ha08, 9'h0ff);
        rd(12'ha18, 9'h0ff);
        rd(12'ha30, 9'h000);
        rd(12'ha3c, 9'h100);
        apb(1'b1, 12'ha30, 8'hff);
        rd(12'ha30, 9'h00d);
        apb(1'b1, 12'ha08, 8'h00);
        apb(1'b1, 12'ha10, 8'h20);
        NAK <= 1'b1;
        apb(1'b1, 12'ha18, 8'h3f);
        repeat (100) @(posedge MCLK);
        NAK <= 1'b0;
        rd(12'ha20, 9'h090);
        repeat (130) @(posedge MCLK);
        chk(got, 9'h180);
        rd(12'ha20, 9'h090);
        apb(1'b1, 12'ha10, 8'h00);
        rd(12'ha20, 9'h090);
        apb(1'b1, 12'ha20, 8'hef);
        rd(12'ha20, 9'h084);
        apb(1'b1, 12'ha10, 8'h20);
        apb(1'b1, 12'ha18, 8'h3b);
        rd(12'ha20, 9'h080);
        // Between the 1.0 and 2.5 etu points
        repeat (88) @(posedge MCLK);
        rd(12'ha20, 9'h080);
        repeat (10) @(posedge MCLK);
        rd(12'ha20, 9'h084);
        chk(got, 9'h189);
        // Guard select 1: done at 1.0 etu, well before 2.5
        apb(1'b1, 12'ha00, 8'h80);
        apb(1'b1, 12'ha18, 8'h3b);
        repeat (80) @(posedge MCLK);
        rd(12'ha20, 9'h080);
        repeat (10) @(posedge MCLK);
        rd(12'ha20, 9'h084);
        // Card receive, direct convention: bad parity, then good
        apb(1'b1, 12'ha10, 8'hd0);
        apb(1'b1, 12'ha30, 8'h01);
        send(9'h001);
        repeat (10) @(posedge MCLK);
        chk({7'h00, DATA_O, DATA_OE_N}, 9'h000);
        rd(12'ha20, 9'h08c);
        chk({6'h00, TXI_REQ, RXI_REQ, ERI_REQ}, 9'h005);
        repeat (16) @(posedge MCLK);
        send(9'h14a);
        repeat (10) @(posedge MCLK);
        chk({8'h00, DATA_OE_N}, 9'h001);
        rd(12'ha28, 9'h0a5);
        rd(12'ha20, 9'h0cc);
        chk({6'h00, TXI_REQ, RXI_REQ, ERI_REQ}, 9'h007);
        STANDBY <= 1'b1;
        repeat (2) @(posedge MCLK);
        STANDBY <= 1'b0;
        rd(12'ha30, 9'h000);
        rd(12'ha20, 9'h084);
        print_verdict();
    end
endmodule : smart_card_serial_mode_test
`default_nettype wire
